// ==== common/gpp_regs.svh ====
// Register indices, reset values and field widths of the pin-control block
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define GPP_IDX_A_DATA 8'h00
`define GPP_IDX_A_PULL 8'h01
`define GPP_IDX_A_DIR 8'h03
`define GPP_IDX_B_DATA 8'h04
`define GPP_IDX_B_PULL 8'h05
`define GPP_IDX_B_DIR 8'h07

// ----------------------------------------
// Address split
// ----------------------------------------
`define GPP_IDX_HI 9
`define GPP_IDX_LO 2
`define GPP_BYTE_OFS 2'h0

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define GPP_A_W 5
`define GPP_B_W 2
`define GPP_A_RST 5'h00
`define GPP_B_RST 2'h0
`define GPP_WORD_ZERO 32'h0000_0000
`define GPP_HTRANS_NSEQ_BIT 1

`endif

// ==== common/gpp_pkg.sv ====
// Types shared by the pin-control block and its users
`include "gpp_regs.svh"
package gpp_pkg;

  // ----------------------------------------
  // Signals from the sharing peripherals
  // ----------------------------------------
  typedef struct packed {
    logic [`GPP_A_W-1:0] dig_en;
    logic [`GPP_A_W-1:0] dig_oe;
    logic [`GPP_A_W-1:0] dig_out;
    logic [`GPP_A_W-1:0] ana_en;
    logic [`GPP_A_W-1:0] keypad_wake_pin_enable;
    logic [`GPP_A_W-1:0] keypad_wake_edge_select;
    logic low_frequency_receiver;
  } gpp_periph_t;

  // ----------------------------------------
  // Pad controls of one port
  // ----------------------------------------
  typedef struct packed {
    logic [`GPP_A_W-1:0] out;
    logic [`GPP_A_W-1:0] oe;
    logic [`GPP_A_W-1:0] ibe;
    logic [`GPP_A_W-1:0] pu;
    logic [`GPP_A_W-1:0] pd;
  } gpp_pad_a_t;

  typedef struct packed {
    logic [`GPP_B_W-1:0] out;
    logic [`GPP_B_W-1:0] oe;
    logic [`GPP_B_W-1:0] ibe;
    logic [`GPP_B_W-1:0] pu;
  } gpp_pad_b_t;

  // ----------------------------------------
  // Bus data-phase kind
  // ----------------------------------------
  typedef enum logic [1:0] {
    GPP_PH_IDLE = 2'h0,
    GPP_PH_WR = 2'h1,
    GPP_PH_RD = 2'h3
  } gpp_phase_t;

endpackage : gpp_pkg

// ==== hw/gpp_port.sv ====
// Seven-pin general purpose port with AHB-Lite register slave
//
// Behaviour
// [R1] Seven pins: five-pin first port, two-pin second port, each individually controlled.
// [R2] Receiver enabled forces both second-port pins to high impedance.
// [R3] An enabled sharing peripheral takes priority over the pin's GPIO function.
// [R4] After reset: peripherals off, all pins inputs, direction and pulls zero.
// [R5] Direction bit enables output buffer and selects data read source.
// [R6] Data read: pin level for inputs, last written latch for outputs.
// [R7] Input buffer always on except while an analog function is enabled; both ports' pad registers hold it off during reset.
// [R8] Digital function drives output buffer; direction still selects read source.
// [R9] Analog function disables both input and output buffers.
// [R10] Input bit with disabled input buffer reads as zero.
// [R11] Analog function wins over a digital function on the same pin.
// [R12] Pull enable bit turns on the pin's internal pull-up.
// [R13] Pull-up off whenever the pin is driven as output by anyone.
// [R14] Pull-up off while the pin is under analog control.
// [R15] First port: keypad enable and edge give pull-down instead; second never.
// [R16] Software writes data before switching a pin to output.
// [R17] Unused pins: input with pull-up, or output driven low.
// [R18] Pins tied to a rail: input with pull-up disabled.
// [R19] Pin levels pass a two-stage synchroniser before reaching reads.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"

module gpp_port #(
  parameter int A_W = `GPP_A_W,
  parameter int B_W = `GPP_B_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire gpp_pkg::gpp_periph_t periph,
  input wire logic [`GPP_A_W-1:0] first_port_pin_in,
  input wire logic [`GPP_B_W-1:0] second_port_pin_in,
  output gpp_pkg::gpp_pad_a_t first_port_pad,
  output gpp_pkg::gpp_pad_b_t second_port_pad
);
  import gpp_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // [R1] Fixed port widths
  if (A_W != `GPP_A_W || B_W != `GPP_B_W) begin : g_bad_width
    $error("gpp_port: port widths must be 5 and 2");
  end

  // Register index field must fit the index width
  if (`GPP_IDX_HI - `GPP_IDX_LO + 1 != 8) begin : g_bad_index
    $error("gpp_port: register index must be eight bits");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [`GPP_A_W-1:0] a_data;
    logic [`GPP_A_W-1:0] a_pull;
    logic [`GPP_A_W-1:0] a_dir;
    logic [`GPP_B_W-1:0] b_data;
    logic [`GPP_B_W-1:0] b_pull;
    logic [`GPP_B_W-1:0] b_dir;
    logic [`GPP_A_W-1:0] a_sync1;
    logic [`GPP_A_W-1:0] a_sync2;
    logic [`GPP_B_W-1:0] b_sync1;
    logic [`GPP_B_W-1:0] b_sync2;
    gpp_phase_t phase;
    logic [7:0] idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    gpp_pad_a_t pad_a;
    gpp_pad_b_t pad_b;
  } gpp_state_t;

  gpp_state_t st_ff;
  gpp_state_t nxt_st;

  // Register values after any data-phase write
  logic [`GPP_A_W-1:0] a_data_nx;
  logic [`GPP_A_W-1:0] a_pull_nx;
  logic [`GPP_A_W-1:0] a_dir_nx;
  logic [`GPP_B_W-1:0] b_data_nx;
  logic [`GPP_B_W-1:0] b_pull_nx;
  logic [`GPP_B_W-1:0] b_dir_nx;

  // First-port pad decisions, combinational
  logic [`GPP_A_W-1:0] a_oe;
  logic [`GPP_A_W-1:0] a_ibe;
  logic [`GPP_A_W-1:0] a_out;
  logic [`GPP_A_W-1:0] a_pu;
  logic [`GPP_A_W-1:0] a_pd;
  logic [`GPP_A_W-1:0] a_rd;

  // Second-port pad decisions, combinational
  logic [`GPP_B_W-1:0] b_oe;
  logic [`GPP_B_W-1:0] b_ibe;
  logic [`GPP_B_W-1:0] b_out;
  logic [`GPP_B_W-1:0] b_pu;
  logic [`GPP_B_W-1:0] b_rd;

  // Address phase decode
  logic take;
  logic [7:0] a_idx;

  // ----------------------------------------
  // Data-phase register writes
  // ----------------------------------------
  always_comb begin
    a_data_nx = st_ff.a_data;
    a_pull_nx = st_ff.a_pull;
    a_dir_nx = st_ff.a_dir;
    b_data_nx = st_ff.b_data;
    b_pull_nx = st_ff.b_pull;
    b_dir_nx = st_ff.b_dir;
    // Only the low pin bits of the word are kept
    if (st_ff.phase == GPP_PH_WR) begin
      unique case (st_ff.idx)
        `GPP_IDX_A_DATA: a_data_nx = hwdata[`GPP_A_W-1:0];
        `GPP_IDX_A_PULL: a_pull_nx = hwdata[`GPP_A_W-1:0];
        `GPP_IDX_A_DIR: a_dir_nx = hwdata[`GPP_A_W-1:0];
        `GPP_IDX_B_DATA: b_data_nx = hwdata[`GPP_B_W-1:0];
        `GPP_IDX_B_PULL: b_pull_nx = hwdata[`GPP_B_W-1:0];
        `GPP_IDX_B_DIR: b_dir_nx = hwdata[`GPP_B_W-1:0];
        default: a_data_nx = st_ff.a_data; // Unmapped writes ignored
      endcase
    end
  end

  // ----------------------------------------
  // First-port pad decisions, one slice per pin
  // ----------------------------------------
  for (genvar i = 0; i < `GPP_A_W; i++) begin : g_pin_a
    logic ana;
    logic dig;
    logic own_oe;
    logic own_out;
    logic pull_ok;
    logic kbd_dn;
    // [R11] Analog owns the pin first
    assign ana = periph.ana_en[i];
    // [R3] Sharing peripheral over GPIO
    assign dig = periph.dig_en[i];
    // [R8] Digital function drives the buffer
    // [R5] Direction enables the buffer
    assign own_oe = dig ? periph.dig_oe[i] : a_dir_nx[i];
    assign own_out = dig ? periph.dig_out[i] : a_data_nx[i];
    // [R9] Analog kills output buffer
    assign a_oe[i] = ~ana & own_oe;
    // Pad level held low while not driven
    assign a_out[i] = a_oe[i] & own_out;
    // [R7] Input buffer on unless analog
    assign a_ibe[i] = ~ana;
    // [R12] Pull enable gates the pull
    // [R13] No pull while driven
    // [R14] No pull under analog
    assign pull_ok = a_pull_nx[i] & ~a_oe[i] & ~ana;
    // [R15] Keypad edge picks pull-down
    assign kbd_dn = periph.keypad_wake_pin_enable[i] & periph.keypad_wake_edge_select[i];
    assign a_pu[i] = pull_ok & ~kbd_dn;
    assign a_pd[i] = pull_ok & kbd_dn;
    // [R6] Latch for outputs, pin for inputs
    // [R10] Disabled input buffer reads zero
    assign a_rd[i] = a_dir_nx[i] ? a_data_nx[i] : (a_ibe[i] & st_ff.a_sync2[i]);
  end

  // ----------------------------------------
  // Second-port pad decisions, one slice per pin
  // ----------------------------------------
  for (genvar i = 0; i < `GPP_B_W; i++) begin : g_pin_b
    logic lf;
    // [R2] Receiver forces high impedance
    assign lf = periph.low_frequency_receiver;
    // [R5] Direction enables the buffer
    assign b_oe[i] = ~lf & b_dir_nx[i];
    // Pad level held low while not driven
    assign b_out[i] = b_oe[i] & b_data_nx[i];
    // [R7] No analog use here, buffer stays on
    assign b_ibe[i] = 1'b1;
    // [R13] No pull while driven
    // [R15] Second port never pulls down
    assign b_pu[i] = b_pull_nx[i] & ~b_oe[i] & ~lf;
    // [R8] Direction still picks the source
    assign b_rd[i] = b_dir_nx[i] ? b_data_nx[i] : (b_ibe[i] & st_ff.b_sync2[i]);
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // [R19] Two-stage pin synchroniser
    nxt_st.a_sync1 = first_port_pin_in;
    nxt_st.a_sync2 = st_ff.a_sync1;
    nxt_st.b_sync1 = second_port_pin_in;
    nxt_st.b_sync2 = st_ff.b_sync1;

    // Control registers after writes
    nxt_st.a_data = a_data_nx;
    nxt_st.a_pull = a_pull_nx;
    nxt_st.a_dir = a_dir_nx;
    nxt_st.b_data = b_data_nx;
    nxt_st.b_pull = b_pull_nx;
    nxt_st.b_dir = b_dir_nx;

    // Pad outputs, registered
    nxt_st.pad_a.oe = a_oe;
    nxt_st.pad_a.ibe = a_ibe;
    nxt_st.pad_a.out = a_out;
    nxt_st.pad_a.pu = a_pu;
    nxt_st.pad_a.pd = a_pd;
    nxt_st.pad_b.oe = b_oe;
    nxt_st.pad_b.ibe = b_ibe;
    nxt_st.pad_b.out = b_out;
    nxt_st.pad_b.pu = b_pu;

    // Address phase acceptance
    take = hsel & hready & htrans[`GPP_HTRANS_NSEQ_BIT];
    a_idx = haddr[`GPP_IDX_HI:`GPP_IDX_LO];
    if (haddr[1:0] != `GPP_BYTE_OFS) begin
      a_idx = 8'hFF; // Misaligned reads as unmapped
    end
    nxt_st.phase = GPP_PH_IDLE;
    nxt_st.ready = 1'b1;
    nxt_st.resp = 1'b0; // Always OKAY
    if (take) begin
      nxt_st.idx = a_idx;
      nxt_st.phase = hwrite ? GPP_PH_WR : GPP_PH_RD;
    end

    // Read data captured at the address phase
    nxt_st.rdata = `GPP_WORD_ZERO;
    if (take && !hwrite) begin
      unique case (a_idx)
        `GPP_IDX_A_DATA: nxt_st.rdata[`GPP_A_W-1:0] = a_rd;
        `GPP_IDX_A_PULL: nxt_st.rdata[`GPP_A_W-1:0] = a_pull_nx;
        `GPP_IDX_A_DIR: nxt_st.rdata[`GPP_A_W-1:0] = a_dir_nx;
        `GPP_IDX_B_DATA: nxt_st.rdata[`GPP_B_W-1:0] = b_rd;
        `GPP_IDX_B_PULL: nxt_st.rdata[`GPP_B_W-1:0] = b_pull_nx;
        `GPP_IDX_B_DIR: nxt_st.rdata[`GPP_B_W-1:0] = b_dir_nx;
        default: nxt_st.rdata = `GPP_WORD_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // [R4] Inputs, no pulls, GPIO owned
      st_ff.a_data <= `GPP_A_RST;
      st_ff.a_pull <= `GPP_A_RST;
      st_ff.a_dir <= `GPP_A_RST;
      st_ff.b_data <= `GPP_B_RST;
      st_ff.b_pull <= `GPP_B_RST;
      st_ff.b_dir <= `GPP_B_RST;
      st_ff.a_sync1 <= `GPP_A_RST;
      st_ff.a_sync2 <= `GPP_A_RST;
      st_ff.b_sync1 <= `GPP_B_RST;
      st_ff.b_sync2 <= `GPP_B_RST;
      st_ff.phase <= GPP_PH_IDLE;
      st_ff.idx <= 8'h00;
      st_ff.rdata <= `GPP_WORD_ZERO;
      st_ff.ready <= 1'b1;
      st_ff.resp <= 1'b0;
      st_ff.pad_a <= '0;
      st_ff.pad_b <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs, straight from flip-flops
  // ----------------------------------------
  assign hrdata = st_ff.rdata;
  assign hreadyout = st_ff.ready;
  assign hresp = st_ff.resp;
  assign first_port_pad = st_ff.pad_a;
  assign second_port_pad = st_ff.pad_b;

endmodule : gpp_port
`default_nettype wire

// ==== bench/gpp_port_asserts.sv ====
// Port checker for the pin-control block
`timescale 1ns/1ps
`default_nettype none
module gpp_port_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire gpp_pkg::gpp_periph_t periph,
  input wire gpp_pkg::gpp_pad_a_t first_port_pad,
  input wire gpp_pkg::gpp_pad_b_t second_port_pad
);
  import gpp_pkg::*;
  gpp_periph_t p_ff;
  // Peripheral inputs one cycle back, matching pad latency
  always_ff @(posedge sys_clk) p_ff <= periph;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rd_upper_zero: assert property (hrdata[31:5] == 27'h000_0000)
    else $error("upper read bits not zero");
  a_rd_idle_zero: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_lf_hiz: assert property (p_ff.low_frequency_receiver |-> (second_port_pad.oe | second_port_pad.pu) == 2'h0)
    else $error("second port driven while receiver on");
  a_ana_bufs_off: assert property (((first_port_pad.oe | first_port_pad.ibe) & p_ff.ana_en) == 5'h00)
    else $error("buffer on under analog use");
  a_ibe_follows_ana: assert property ($past(rst_n) |-> first_port_pad.ibe == ~p_ff.ana_en)
    else $error("input buffer not following analog enable");
  a_dig_owns_oe: assert property ($past(rst_n) |->
    ((first_port_pad.oe ^ p_ff.dig_oe) & p_ff.dig_en & ~p_ff.ana_en) == 5'h00)
    else $error("digital function not driving enable");
  a_dig_owns_out: assert property (((first_port_pad.out ^ p_ff.dig_out) & first_port_pad.oe & p_ff.dig_en) == 5'h00)
    else $error("digital function not driving level");
  a_pull_off_drive: assert property ((first_port_pad.pu & (first_port_pad.oe | p_ff.ana_en)) == 5'h00 &&
    (second_port_pad.pu & second_port_pad.oe) == 2'h0)
    else $error("pull-up on while driven or analog");
  a_pd_keypad: assert property ((first_port_pad.pd & (first_port_pad.pu |
    ~(p_ff.keypad_wake_pin_enable & p_ff.keypad_wake_edge_select))) == 5'h00)
    else $error("pull-down without keypad setting");
  a_reset_inputs: assert property (disable iff (1'b0) !rst_n |=>
    (first_port_pad.oe | first_port_pad.pu) == 5'h00 && second_port_pad.oe == 2'h0)
    else $error("pin driven or pulled in reset");
  c_lf: cover property (p_ff.low_frequency_receiver);
  c_ana_dig: cover property ((p_ff.ana_en & p_ff.dig_en) != 5'h00);
  c_pd: cover property (first_port_pad.pd != 5'h00);
endmodule : gpp_port_asserts
`default_nettype wire

// ==== bench/gpp_pin_model.sv ====
// Board and pad model giving each pin its level
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_pin_model (
  input wire gpp_pkg::gpp_pad_a_t first_port_pad,
  input wire gpp_pkg::gpp_pad_b_t second_port_pad,
  input wire logic [`GPP_A_W-1:0] ext_a,
  input wire logic [`GPP_B_W-1:0] ext_b,
  output logic [`GPP_A_W-1:0] first_port_pin_in,
  output logic [`GPP_B_W-1:0] second_port_pin_in
);
  import gpp_pkg::*;
  // Driver wins, then pulls, then the weak board level
  assign first_port_pin_in = (first_port_pad.oe & first_port_pad.out) |
    (~first_port_pad.oe & (first_port_pad.pu | (ext_a & ~first_port_pad.pd)));
  assign second_port_pin_in = (second_port_pad.oe & second_port_pad.out) |
    (~second_port_pad.oe & (second_port_pad.pu | ext_b));
endmodule : gpp_pin_model
`default_nettype wire

// ==== bench/gpp_port_pin_control_tb_top.sv ====
// Testbench for the pin-control block
`timescale 1ns/1ps
`default_nettype none
`include "gpp_regs.svh"
module gpp_port_pin_control_tb_top;
  import gpp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready;
  logic hresp;
  gpp_periph_t periph = '0;
  gpp_pad_a_t pad_a;
  gpp_pad_b_t pad_b;
  logic [4:0] pin_a;
  logic [1:0] pin_b;
  logic [4:0] ext_a = 5'h15;
  logic [1:0] ext_b = 2'h2;
  logic [7:0] idx_l [6] = '{`GPP_IDX_A_PULL, `GPP_IDX_A_DIR, `GPP_IDX_B_PULL, `GPP_IDX_B_DIR, 8'h02, 8'h06};
  int miscompares = 0;
  int num_checks = 0;
  always #4 sys_clk = ~sys_clk;
  gpp_port gpp_port_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .periph(periph), .first_port_pin_in(pin_a), .second_port_pin_in(pin_b),
    .first_port_pad(pad_a), .second_port_pad(pad_b));
  gpp_pin_model gpp_pin_model_inst (.first_port_pad(pad_a), .second_port_pad(pad_b), .ext_a(ext_a),
    .ext_b(ext_b), .first_port_pin_in(pin_a), .second_port_pin_in(pin_b));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One AHB single transfer; hready sampled at the falling edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    logic r;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h00_0000, idx, `GPP_BYTE_OFS};
    do begin
      @(negedge sys_clk);
      r = hready;
      @(posedge sys_clk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge sys_clk);
      r = hready;
      rd = hrdata;
      @(posedge sys_clk);
    end while (r !== 1'b1);
  endtask : xfer
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rchk
  // Lets pads and pin synchronisers catch up
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (idx_l[i]) rchk("ctl_reg", idx_l[i], 32'h0000_0000);
    rchk("a_data_pin", `GPP_IDX_A_DATA, 32'h0000_0015);
    rchk("b_data_pin", `GPP_IDX_B_DATA, 32'h0000_0002);
    chk("a_oe_rst", 32'h0000_0000, 32'(pad_a.oe));
    chk("hresp", 32'h0000_0000, 32'(hresp));
    xfer(1'b1, `GPP_IDX_A_DATA, 32'hFFFF_FF0A);
    xfer(1'b1, `GPP_IDX_A_DIR, 32'h0000_001F);
    rchk("a_data_latch", `GPP_IDX_A_DATA, 32'h0000_000A);
    settle();
    chk("a_out", 32'h0000_000A, 32'(pad_a.out));
    xfer(1'b1, `GPP_IDX_A_DIR, 32'h0000_0003);
    settle();
    rchk("a_data_mix", `GPP_IDX_A_DATA, 32'h0000_0016);
    periph.keypad_wake_pin_enable <= 5'h0C;
    periph.keypad_wake_edge_select <= 5'h0A;
    xfer(1'b1, `GPP_IDX_A_DIR, 32'h0000_0000);
    xfer(1'b1, `GPP_IDX_A_PULL, 32'h0000_001F);
    settle();
    chk("a_pu", 32'h0000_0017, 32'(pad_a.pu));
    chk("a_pd", 32'h0000_0008, 32'(pad_a.pd));
    rchk("a_data_pull", `GPP_IDX_A_DATA, 32'h0000_0017);
    periph.ana_en <= 5'h01;
    periph.dig_en <= 5'h03;
    periph.dig_oe <= 5'h03;
    periph.dig_out <= 5'h02;
    settle();
    chk("a_oe_dig", 32'h0000_0002, 32'(pad_a.oe));
    chk("a_out_dig", 32'h0000_0002, 32'(pad_a.out));
    chk("a_ibe", 32'h0000_001E, 32'(pad_a.ibe));
    chk("a_pu_drv", 32'h0000_0014, 32'(pad_a.pu));
    rchk("a_data_ana", `GPP_IDX_A_DATA, 32'h0000_0016);
    xfer(1'b1, `GPP_IDX_B_DATA, 32'h0000_0003);
    xfer(1'b1, `GPP_IDX_B_DIR, 32'h0000_0003);
    settle();
    chk("b_oe", 32'h0000_0003, 32'(pad_b.oe));
    chk("b_out", 32'h0000_0003, 32'(pad_b.out));
    chk("b_ibe", 32'h0000_0003, 32'(pad_b.ibe));
    periph.low_frequency_receiver <= 1'b1;
    settle();
    chk("b_oe_lf", 32'h0000_0000, 32'(pad_b.oe));
    chk("b_pu_lf", 32'h0000_0000, 32'(pad_b.pu));
    rchk("b_data_lf", `GPP_IDX_B_DATA, 32'h0000_0003);
    print_verdict();
  end
endmodule : gpp_port_pin_control_tb_top
bind gpp_port gpp_port_asserts gpp_port_asserts_inst (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .periph(periph),
  .first_port_pad(first_port_pad), .second_port_pad(second_port_pad));
`default_nettype wire
